// [verilog/scsc_top.sv]
/*
  Serial configuration streamer: stores a bitstream and shifts it to a
  target logic device, as chain master or slave, with cascade hand-off,
  done timeout and error signalling on the shared reset/enable line.
  Assumes sys_rst_i is the power-on reset, the pins are resolved outside
  from the _o/_oe_o pairs, and the JTAG decode runs on clk_sys_i.
*/
`timescale 1ns/1ns
// Notes on behaviour
// [RULE_01] Low reset/enable line clears address counter and floats data.
// [RULE_02] Select high after the reset pulse: counter off, data floats.
// [RULE_03] Select low after the reset pulse: counter runs, data driven.
// [RULE_04] Any new low on the line resets, regardless of select.
// [RULE_05] Line and select both low after reset: become master. Code: master only with line high and select low on leaving ST_HOLD.
// [RULE_06] Select high after reset: slave, data floats, clock is input.
// [RULE_07] Master drives bit clock and sends the first bits.
// [RULE_08] Master after its last bit floats data, then pulls cascade low. Code: both in the same clock cycle.
// [RULE_09] Slave starts sending when select pulled low, on master clock.
// [RULE_10] Master keeps clocking until the whole transfer is done.
// [RULE_11] Done seen: idle, clock low, data high or floated per variant.
// [RULE_12] Select high before all bits sent: master pulls line low.
// [RULE_13] No done within 16 bit clocks after last bit: pull line low. Code: only a master with HAS_SLAVES clear times out.
// [RULE_14] With auto-restart set, configuration restarts after an error.
// [RULE_15] JTAG start instruction pulls start output low; release on exit.
// [RULE_16] System chains cascade to next select, shares clock/data/line.
// [RULE_17] Target done output drives the master select input.
// [RULE_18] Pull-ups on line and select enabled unless option disables.
// [RULE_19] Reset/enable line is open drain, only ever pulled low.
// [RULE_20] Bits shift out serially; master clock from internal divider.
// [RULE_21] Line held low during power-on reset, released after.
// [RULE_22] Target pulling the line low resets the device.
// [RULE_23] Counter advances one bit per bit clock; parameter marks last.
module scsc_top
  import scsc_pkg::*;
#(
  parameter int TOTAL_BITS = STORED_BITS,
  parameter int POR_CNT    = POR_CYCLES,
  parameter int HALF_CNT   = BCLK_HALF,
  parameter bit HAS_SLAVES = 1'b0
) (
  // Clock and reset
  input  wire logic                          clk_sys_i,
  input  wire logic                          sys_rst_i,
  // Reset/enable line, open drain
  input  wire logic                          rst_en_i,
  output logic                               rst_en_o,
  output logic                               rst_en_oe_o,
  // Chain handshake
  input  wire logic                          chain_select_in_n_i,
  output logic                               cascade_out_n_o,
  // Bit clock, two-way
  input  wire logic                          bit_clock_i,
  output logic                               bit_clock_o,
  output logic                               bit_clock_oe_o,
  // Serial data
  output logic                               data_o,
  output logic                               data_oe_o,
  // Start-configuration pin and JTAG request
  input  wire logic                          jtag_start_conf_i,
  output logic                               start_conf_n_o,
  output logic                               start_conf_oe_o,
  // Stored options
  input  wire logic                          auto_restart_i,
  input  wire logic                          pullup_disable_i,
  input  wire logic                          idle_data_high_i,
  output logic                               rst_en_pullup_o,
  output logic                               chain_sel_pullup_o,
  // Bit memory load port
  input  wire logic                          mem_wr_i,
  input  wire logic [$clog2(TOTAL_BITS)-1:0] mem_addr_i,
  input  wire logic                          mem_bit_i
);

  localparam int AW = $clog2(TOTAL_BITS);
  localparam int CW = $clog2(TOTAL_BITS + 1);
  localparam int PCW = $clog2(POR_CNT + 1);

  initial
  begin
    if (TOTAL_BITS < 2 || HALF_CNT < 1 || HALF_CNT > 8 || POR_CNT < 1)
      $error("scsc_top: unsupported parameter value");
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [2:0] in_s1_ff;
  logic [2:0] in_s2_ff;
  logic       bclk_prev_ff;

  always_ff @(posedge clk_sys_i)
  begin
    in_s1_ff     <= {bit_clock_i, chain_select_in_n_i, rst_en_i};
    in_s2_ff     <= in_s1_ff;
    bclk_prev_ff <= in_s2_ff[2];
  end

  wire line_low = ~in_s2_ff[0];
  wire sel_high = in_s2_ff[1];
  wire s_tick   = bclk_prev_ff & ~in_s2_ff[2];

  // ----------------------------------------
  // State and counters
  // ----------------------------------------
  scsc_state_type      state_ff;
  scsc_state_type      nxt_state;
  logic                master_ff;
  logic [PCW-1:0]      por_cnt_ff;
  logic [3:0]          err_cnt_ff;
  logic [3:0]          wait_cnt_ff;
  logic [AW:0]         addr_ff;
  logic [CW-1:0]       sent_ff;
  logic [$clog2(HALF_CNT+1)-1:0] div_cnt_ff;
  logic                bclk_ff;
  logic                data_ff;
  logic                start_oe_ff;
  logic                pullup_ff;
  logic                mem_ff [TOTAL_BITS];

  wire in_send   = state_ff == ST_SEND;
  wire in_casc   = state_ff == ST_CASC;
  wire in_dwait  = state_ff == ST_DWAIT;
  wire in_idle   = state_ff == ST_IDLE;
  wire in_error  = state_ff == ST_ERROR;
  wire bclk_run  = master_ff & (in_send | in_casc | in_dwait);
  wire div_wrap  = div_cnt_ff == ($bits(div_cnt_ff))'(HALF_CNT - 1);
  wire m_tick    = bclk_run & div_wrap & bclk_ff;
  wire tick      = master_ff ? m_tick : s_tick;
  wire last_sent = sent_ff == CW'(TOTAL_BITS);
  wire err_done  = err_cnt_ff == 4'(ERR_CYCLES - 1);
  wire wait_done = wait_cnt_ff == 4'(DONE_WAIT_BITS - 1);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_POR:
        if (por_cnt_ff == '0)
          nxt_state = ST_HOLD;                                   // RULE_21
      ST_ERROR:
        if (err_done)
          nxt_state = auto_restart_i ? ST_HOLD : ST_HALT;        // RULE_14
      ST_HALT:
        nxt_state = ST_HALT;
      default:
        if (line_low)
          nxt_state = ST_HOLD;                                   // RULE_04 RULE_22
        else
          case (state_ff)
            ST_HOLD:
              nxt_state = sel_high ? ST_SLAVE : ST_SEND;         // RULE_02 RULE_03
            ST_SLAVE:
              if (!sel_high)
                nxt_state = ST_SEND;                             // RULE_09
            ST_SEND:
              if (master_ff && sel_high)
                nxt_state = ST_ERROR;                            // RULE_12
              else if (tick && last_sent)
                nxt_state = (master_ff && !HAS_SLAVES) ? ST_DWAIT : ST_CASC;
            ST_CASC:
              if (master_ff && sel_high)
                nxt_state = ST_IDLE;                             // RULE_10
            ST_DWAIT:
              if (sel_high)
                nxt_state = ST_IDLE;                             // RULE_11
              else if (tick && wait_done)
                nxt_state = ST_ERROR;                            // RULE_13
            default:
              nxt_state = state_ff;
          endcase
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      state_ff <= ST_POR;
    else
      state_ff <= nxt_state;
  end

  // Role is taken only when leaving the reset pulse.
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i || state_ff == ST_HOLD && line_low)
      master_ff <= RST_MASTER;
    else if (state_ff == ST_HOLD)
      master_ff <= ~sel_high;                                    // RULE_05
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      por_cnt_ff <= PCW'(POR_CNT - 1);
    else if (por_cnt_ff != '0)
      por_cnt_ff <= por_cnt_ff - 1'b1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i || !in_error)
      err_cnt_ff <= '0;
    else if (!err_done)
      err_cnt_ff <= err_cnt_ff + 1'b1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i || !in_dwait)
      wait_cnt_ff <= '0;
    else if (tick)
      wait_cnt_ff <= wait_cnt_ff + 1'b1;                         // RULE_13
  end

  // ----------------------------------------
  // Master bit clock divider
  // ----------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i || !bclk_run)
    begin
      div_cnt_ff <= '0;
      bclk_ff    <= RST_BCLK;                                    // RULE_11
    end
    else if (div_wrap)
    begin
      div_cnt_ff <= '0;
      bclk_ff    <= ~bclk_ff;                                    // RULE_20
    end
    else
      div_cnt_ff <= div_cnt_ff + 1'b1;
  end

  // ----------------------------------------
  // Bit memory, fetch and shifter
  // ----------------------------------------
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_data;
  wire  fetch     = in_send & (addr_ff < (AW+1)'(TOTAL_BITS));
  wire  pop       = tick & in_send & ~last_sent;
  wire  buf_clear = ~in_send;                                    // RULE_01

  always_ff @(posedge clk_sys_i)
  begin
    if (mem_wr_i)
      mem_ff[mem_addr_i] <= mem_bit_i;
  end

  // Fetch runs ahead of the shifter by at most the buffer depth.
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i || !in_send)
      addr_ff <= '0;                                             // RULE_01
    else if (fetch && buf_in_ready)
      addr_ff <= addr_ff + 1'b1;                                 // RULE_23
  end

  scsc_buf2 #(
    .WIDTH (1),
    .DEPTH (2)
  ) u_buf (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .clear_i     (buf_clear),
    .in_valid_i  (fetch),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (mem_ff[addr_ff[AW-1:0]]),
    .out_valid_o (buf_out_valid),
    .out_ready_i (pop),
    .out_data_o  (buf_out_data)
  );

  // Data changes on the falling bit clock edge; target samples on rising.
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i || !in_send)
      sent_ff <= '0;
    else if (pop && buf_out_valid)
      sent_ff <= sent_ff + 1'b1;                                 // RULE_23
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      data_ff <= RST_DATA;
    else if (nxt_state == ST_IDLE)
      data_ff <= 1'b1;
    else if (pop && buf_out_valid)
      data_ff <= buf_out_data;                                   // RULE_07
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      start_oe_ff <= 1'b0;
      pullup_ff   <= 1'b1;
    end
    else
    begin
      start_oe_ff <= jtag_start_conf_i;                          // RULE_15
      pullup_ff   <= ~pullup_disable_i;                          // RULE_18
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  assign rst_en_o           = 1'b0;                              // RULE_19
  assign rst_en_oe_o        = state_ff == ST_POR | in_error | state_ff == ST_HALT;
  assign data_o             = data_ff;
  assign data_oe_o          = in_send | (in_idle & master_ff & idle_data_high_i);
  assign bit_clock_o        = bclk_ff;
  assign bit_clock_oe_o     = master_ff & (bclk_run | in_idle);  // RULE_06 RULE_07
  assign cascade_out_n_o    = ~(in_casc | in_dwait | in_idle);   // RULE_08
  assign start_conf_n_o     = 1'b0;
  assign start_conf_oe_o    = start_oe_ff;
  assign rst_en_pullup_o    = pullup_ff;
  assign chain_sel_pullup_o = pullup_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  a_low_floats_data: assert property (line_low |=> !data_oe_o || in_idle) // RULE_01
    else $error("data driven after line low");
  a_low_clears_addr: assert property (line_low ##1 line_low |=> addr_ff == '0) // RULE_04
    else $error("address not cleared by line low");
  a_slave_floats: assert property (state_ff == ST_SLAVE |-> !data_oe_o && !bit_clock_oe_o) // RULE_06
    else $error("slave drives data or clock");
  a_master_pick: assert property (state_ff == ST_HOLD && !line_low && !sel_high
                                  |=> in_send && master_ff && data_oe_o) // RULE_05
    else $error("master role not taken");
  a_slave_pick: assert property (state_ff == ST_HOLD && !line_low && sel_high
                                 |=> state_ff == ST_SLAVE && !master_ff) // RULE_02
    else $error("slave role not taken");
  a_early_error: assert property (in_send && master_ff && sel_high && !line_low
                                  |=> in_error && rst_en_oe_o) // RULE_12
    else $error("early done not flagged");
  a_done_timeout: assert property (in_dwait && tick && wait_done && !sel_high && !line_low
                                   |=> rst_en_oe_o) // RULE_13
    else $error("done timeout not flagged");
  a_cascade_float: assert property ($fell(cascade_out_n_o) |-> !data_oe_o) // RULE_08
    else $error("cascade asserted while data driven");
  a_clock_runs: assert property (master_ff && (in_casc || in_dwait) && div_cnt_ff == '0
                                 |-> ##[1:8] ($changed(bit_clock_o) || !(in_casc || in_dwait))) // RULE_10
    else $error("master bit clock stalled");
  a_idle_clock_low: assert property (in_idle ##1 in_idle |-> !bit_clock_o) // RULE_11
    else $error("bit clock not low in idle");
  a_auto_restart: assert property (in_error && err_done && auto_restart_i
                                   |=> state_ff == ST_HOLD ##1 !rst_en_oe_o) // RULE_14
    else $error("no restart after error");
  a_jtag_pull: assert property (jtag_start_conf_i |=> start_conf_oe_o && !start_conf_n_o) // RULE_15
    else $error("start output not pulled");
  a_jtag_release: assert property (!jtag_start_conf_i |=> !start_conf_oe_o) // RULE_15
    else $error("start output not released");

  c_master_done: cover property (in_dwait ##1 in_idle);
  c_slave_send: cover property (state_ff == ST_SLAVE ##1 in_send);
  c_error: cover property (in_send ##1 in_error);
  c_restart: cover property (in_error ##1 state_ff == ST_HOLD);

endmodule // scsc_top

// [verilog/scsc_pkg.sv]
/*
  Constants, timing and state codes of the serial configuration streamer.
  Assumes a 100 MHz system clock; all times are converted to cycles here.
*/
package scsc_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_MHZ        = 100;
  localparam int POR_MAX_MS     = 200;
  localparam int POR_CYCLES     = POR_MAX_MS * 1000 * CLK_MHZ;
  localparam int BCLK_HALF      = 4;
  localparam int DONE_WAIT_BITS = 16;
  localparam int ERR_CYCLES     = 16;
  localparam int STORED_BITS    = 1024;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic RST_DATA     = 1'b0;
  localparam logic RST_BCLK     = 1'b0;
  localparam logic RST_MASTER   = 1'b0;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [8:0] {
    ST_POR   = 9'h001,
    ST_HOLD  = 9'h002,
    ST_SLAVE = 9'h004,
    ST_SEND  = 9'h008,
    ST_CASC  = 9'h010,
    ST_DWAIT = 9'h020,
    ST_IDLE  = 9'h040,
    ST_ERROR = 9'h080,
    ST_HALT  = 9'h100
  } scsc_state_type;

endpackage

// [verilog/scsc_buf2.sv]
/*
  Small FIFO between the bit memory and the serial shifter.
  Assumes one clock; clear_i empties it in one cycle.
*/
`timescale 1ns/1ns
module scsc_buf2 #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             sys_rst_i,
  input  wire logic             clear_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int PW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0]    wr_ptr_ff;
  logic [PW-1:0]    rd_ptr_ff;
  logic [PW:0]      count_ff;
  wire              push = in_valid_i & in_ready_o;
  wire              pop  = out_valid_o & out_ready_i;

  assign in_ready_o  = count_ff != (PW+1)'(DEPTH);
  assign out_valid_o = count_ff != '0;
  assign out_data_o  = mem_ff[rd_ptr_ff];

  always_ff @(posedge clk_sys_i)
  begin
    if (push)
      mem_ff[wr_ptr_ff] <= in_data_i;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i || clear_i)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end
    else
    begin
      wr_ptr_ff <= wr_ptr_ff + PW'(push);
      rd_ptr_ff <= rd_ptr_ff + PW'(pop);
      count_ff  <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule // scsc_buf2

// [dv/scsc_target_model.sv]
/*
  Far-side model: the target logic device that receives the serial stream.
  Assumes the bench resolves the line, select, clock and data wires.
*/
`timescale 1ns/1ns
module scsc_target_model #(
  parameter int NBITS = 32
) (
  // Link wires
  input  wire logic             bit_clock_i,
  input  wire logic             data_i,
  input  wire logic             drive_i,
  input  wire logic             line_i,
  // Bench controls
  input  wire logic             done_en_i,
  input  wire logic             early_done_i,
  input  wire logic             crc_err_i,
  // Status and capture
  output logic                  status_pull_o,
  output logic                  done_o,
  output logic      [NBITS-1:0] rx_bits_o,
  output int                    rx_count_o
);
  int   extra_ff;
  logic armed_ff;

  // ----------------------------------------
  // Capture on rising bit clock
  // ----------------------------------------
  // Rises before the first driven fall carry no bit yet
  always @(negedge bit_clock_i or negedge line_i)
    if (!line_i)
      armed_ff <= 1'b0;
    else if (drive_i)
      armed_ff <= 1'b1;

  always @(posedge bit_clock_i or negedge line_i)
    if (!line_i)
    begin
      rx_count_o <= 0;
      extra_ff   <= 0;
    end
    else if (armed_ff && rx_count_o < NBITS)
    begin
      rx_bits_o[rx_count_o] <= data_i;
      rx_count_o            <= rx_count_o + 1;
    end
    else if (armed_ff && extra_ff < 3)
      extra_ff <= extra_ff + 1;

  // Done stays low while loading unless early_done_i is set; with done_en_i, rises two clocks after the last bit
  assign done_o        = early_done_i | (done_en_i && extra_ff >= 2);
  assign status_pull_o = crc_err_i;
endmodule // scsc_target_model

// [dv/tb_scsc_top.sv]
/*
  Self-checking bench for the serial configuration streamer.
  Assumes the target model on the far side and a 100 MHz system clock.
*/
`timescale 1ns/1ns
module tb_scsc_top
  import scsc_pkg::*;
  ;
  localparam int          NB    = 32;
  localparam int          POR_N = 40;
  localparam int          HALF  = 4;
  localparam int          LIMIT = 20000;
  localparam logic [31:0] PAT   = 32'hC3A5_5A1E;

  logic clk_sys_i, sys_rst_i, jtag, auto_rs, pu_dis, idle_hi, mem_wr, mem_bit;
  logic prev_casc_n, tb_bclk, done_en, early_done, crc_err;
  logic rst_en_o, rst_en_oe_o, cascade_out_n_o, bit_clock_o, bit_clock_oe_o;
  logic data_o, data_oe_o, start_conf_n_o, start_conf_oe_o, rst_en_pullup_o, chain_sel_pullup_o;
  logic          [4:0] mem_addr;
  logic       [NB-1:0] rx_bits;
  wire logic           line_w, sel_w, bclk_w, data_w, st_pull, done_w;
  int                  rx_count;
  int                  fail_count = 0;
  int                  cmp_count  = 0;
  int                  cyc        = 0;

  // ----------------------------------------
  // Wire resolution and instances
  // ----------------------------------------
  // Open drain: the pulled level is whatever the design puts on rst_en_o
  assign line_w = (rst_en_oe_o ? rst_en_o : 1'b1) & ~st_pull;
  assign sel_w  = done_w | prev_casc_n;
  assign bclk_w = bit_clock_oe_o ? bit_clock_o : tb_bclk;
  // Released data shows the inverse, so a stale bit never matches
  assign data_w = data_oe_o ? data_o : ~data_o;

  scsc_top #(.TOTAL_BITS(NB), .POR_CNT(POR_N), .HALF_CNT(HALF), .HAS_SLAVES(1'b0)) u_dut (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .rst_en_i(line_w), .rst_en_o(rst_en_o),
    .rst_en_oe_o(rst_en_oe_o), .chain_select_in_n_i(sel_w), .cascade_out_n_o(cascade_out_n_o),
    .bit_clock_i(bclk_w), .bit_clock_o(bit_clock_o), .bit_clock_oe_o(bit_clock_oe_o),
    .data_o(data_o), .data_oe_o(data_oe_o), .jtag_start_conf_i(jtag),
    .start_conf_n_o(start_conf_n_o), .start_conf_oe_o(start_conf_oe_o), .auto_restart_i(auto_rs),
    .pullup_disable_i(pu_dis), .idle_data_high_i(idle_hi), .rst_en_pullup_o(rst_en_pullup_o),
    .chain_sel_pullup_o(chain_sel_pullup_o), .mem_wr_i(mem_wr), .mem_addr_i(mem_addr),
    .mem_bit_i(mem_bit));

  scsc_target_model #(.NBITS(NB)) u_target (
    .bit_clock_i(bclk_w), .data_i(data_w), .drive_i(data_oe_o), .line_i(line_w),
    .done_en_i(done_en), .early_done_i(early_done), .crc_err_i(crc_err),
    .status_pull_o(st_pull), .done_o(done_w), .rx_bits_o(rx_bits), .rx_count_o(rx_count));

  // ----------------------------------------
  // Common tasks
  // ----------------------------------------
  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  task automatic wait_rx(input int n, input int lim);
    for (int k = 0; k < lim && rx_count < n; k++) @(negedge clk_sys_i);
  endtask

  // Link clock of 80 ns: short high phase leaves the slave time to shift
  task automatic lclk(input int n);
    repeat (n)
    begin
      tb_bclk = 1'b1;
      tick(2);
      tb_bclk = 1'b0;
      tick(6);
    end
  endtask

  // Reset, then load the bit memory while the line is still held
  task automatic boot(input logic ar, input logic idle, input logic prev, input logic den);
    int cnt;
    sys_rst_i   = 1'b1;
    auto_rs     = ar;
    idle_hi     = idle;
    prev_casc_n = prev;
    done_en     = den;
    early_done  = 1'b0;
    crc_err     = 1'b0;
    tb_bclk     = 1'b0;
    tick(5);
    sys_rst_i = 1'b0;
    // The release cycle itself is already pulled
    cnt       = 1;
    for (int i = 0; i < 200; i++)
    begin
      mem_wr   = (i < NB);
      mem_addr = 5'(i);
      mem_bit  = PAT[i % NB];
      @(negedge clk_sys_i);
      if (!rst_en_oe_o)
        break;
      cnt++;
    end
    mem_wr = 1'b0;
    chk1(cnt >= POR_N && cnt <= POR_N + 2, 1'b1);
    tick(8);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_master(input logic idle);
    boot(1'b0, idle, 1'b0, 1'b1);
    chk1(bit_clock_oe_o, 1'b1);
    wait_rx(NB, 800);
    chkv(rx_bits, PAT);
    for (int k = 0; k < 20 && data_oe_o; k++) @(negedge clk_sys_i);
    chk1(data_oe_o, 1'b0);
    chk1(cascade_out_n_o, 1'b0);
    tick(80);
    chk1(line_w, 1'b1);
    chk1(bclk_w, 1'b0);
    chk1(data_oe_o, idle);
    if (idle)
      chk1(data_o, 1'b1);
  endtask

  task automatic t_timeout();
    int cnt;
    boot(1'b0, 1'b0, 1'b0, 1'b0);
    wait_rx(NB, 800);
    for (int k = 0; k < 20 && data_oe_o; k++) @(negedge clk_sys_i);
    for (cnt = 0; cnt < 300 && !rst_en_oe_o; cnt++) @(negedge clk_sys_i);
    chkv(32'(cnt), 32'(DONE_WAIT_BITS * 2 * HALF));
    tick(100);
    chk1(line_w, 1'b0);
  endtask

  task automatic t_early();
    int cnt;
    boot(1'b1, 1'b0, 1'b0, 1'b1);
    wait_rx(10, 400);
    early_done = 1'b1;
    for (int k = 0; k < 20 && !rst_en_oe_o; k++) @(negedge clk_sys_i);
    chk1(rst_en_oe_o, 1'b1);
    early_done = 1'b0;
    for (cnt = 1; cnt < 40 && rst_en_oe_o; cnt++) @(negedge clk_sys_i);
    chk1(cnt >= ERR_CYCLES && cnt <= ERR_CYCLES + 1, 1'b1);
    wait_rx(NB, 800);
    chkv(rx_bits, PAT);
  endtask

  task automatic t_abort();
    boot(1'b0, 1'b0, 1'b0, 1'b1);
    wait_rx(12, 400);
    crc_err = 1'b1;
    tick(6);
    chk1(data_oe_o, 1'b0);
    crc_err = 1'b0;
    wait_rx(NB, 800);
    chkv(rx_bits, PAT);
  endtask

  task automatic t_slave();
    boot(1'b0, 1'b0, 1'b1, 1'b1);
    chk1(data_oe_o, 1'b0);
    chk1(bit_clock_oe_o, 1'b0);
    lclk(3);
    chkv(32'(rx_count), 32'h0000_0000);
    prev_casc_n = 1'b0;
    tick(10);
    chk1(data_oe_o, 1'b1);
    lclk(NB + 2);
    chkv(rx_bits, PAT);
    chk1(data_oe_o, 1'b0);
    chk1(cascade_out_n_o, 1'b0);
    crc_err = 1'b1;
    tick(6);
    chk1(cascade_out_n_o, 1'b1);
    chk1(data_oe_o, 1'b0);
    crc_err = 1'b0;
  endtask

  task automatic t_misc();
    chk1(rst_en_pullup_o, 1'b1);
    jtag = 1'b1;
    tick(2);
    chk1(start_conf_oe_o, 1'b1);
    chk1(start_conf_n_o, 1'b0);
    jtag   = 1'b0;
    pu_dis = 1'b1;
    tick(2);
    chk1(start_conf_oe_o, 1'b0);
    chk1(chain_sel_pullup_o, 1'b0);
    chk1(rst_en_pullup_o, 1'b0);
    pu_dis = 1'b0;
    tick(2);
    chk1(chain_sel_pullup_o, 1'b1);
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // Ceiling well above the roughly 2600 cycles the scenarios need
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      fail_count++;
      report_and_stop();
    end
  end

  initial
  begin
    jtag     = 1'b0;
    pu_dis   = 1'b0;
    mem_wr   = 1'b0;
    mem_addr = 5'h00;
    mem_bit  = 1'b0;
    t_master(1'b0);
    t_misc();
    t_master(1'b1);
    t_timeout();
    t_early();
    t_abort();
    t_slave();
    report_and_stop();
  end
endmodule // tb_scsc_top
